// ### bench/cpu_model.sv
// CPU side model: counts watchdog resets and interrupts, times each one.
// Assumes active-high, registered reset and interrupt lines from the block.
module cpu_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic cpu_reset_i,
    input  wire logic nmi_i,
    output int        resets_o,
    output int        nmis_o,
    output int        rst_len_o,
    output int        stamp_o,
    output logic      nmi_long_o
);
    timeunit 1ns;
    timeprecision 1ps;

    int   cycle_q;
    int   run_q;
    logic nmi_q;

    // -----------------------------------------------------------------
    // Event tracking
    // -----------------------------------------------------------------
    // Pulse counting, widths and time stamps
    always_ff @(posedge clk_i) begin
        cycle_q <= cycle_q + 1;
        nmi_q   <= nmi_i;
        if (rst_i) begin
            resets_o   <= 0;
            nmis_o     <= 0;
            rst_len_o  <= 0;
            run_q      <= 0;
            nmi_long_o <= 1'b0;
        end else begin
            if (cpu_reset_i) begin
                run_q <= run_q + 1;
                if (run_q == 0) begin
                    resets_o <= resets_o + 1;
                    stamp_o  <= cycle_q;
                end
            end else if (run_q != 0) begin
                rst_len_o <= run_q;
                run_q     <= 0;
            end
            if (nmi_i && !nmi_q) begin
                nmis_o  <= nmis_o + 1;
                stamp_o <= cycle_q;
            end
            if (nmi_i && nmi_q) begin
                nmi_long_o <= 1'b1;
            end
        end
    end
endmodule // cpu_model

// ### bench/testbench.sv
// Self-checking bench for the watchdog control block over Wishbone.
// Assumes the shortened periods below and the CPU model beside it.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import watchdog_pkg::*;

    localparam int PER [4] = '{16, 32, 64, 128};

    logic        clk_i, rst_i, we, cyc, stb, ack_o, irq_o, cpu_reset_o, nmi_o;
    logic [7:0]  adr;
    logic [31:0] dat, dat_o, q;
    logic [3:0]  sel;
    logic        nmi_long;
    int          resets, nmis, rst_len, stamp, failures, n_checks, s, r;

    watchdog_timer_control #(.PERIOD_SEL_00(PER[0]), .PERIOD_SEL_01(PER[1]),
        .PERIOD_SEL_10(PER[2]), .PERIOD_SEL_11(PER[3])) watchdog_timer_control_inst (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat), .dat_o(dat_o),
        .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack_o),
        .irq_o(irq_o), .cpu_reset_o(cpu_reset_o), .nmi_o(nmi_o));

    cpu_model cpu_model_inst (.clk_i(clk_i), .rst_i(rst_i), .cpu_reset_i(cpu_reset_o),
        .nmi_i(nmi_o), .resets_o(resets), .nmis_o(nmis), .rst_len_o(rst_len),
        .stamp_o(stamp), .nmi_long_o(nmi_long));

    // -----------------------------------------------------------------
    // Compare, bus and wait tasks
    // -----------------------------------------------------------------
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_cnt(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        adr <= a;
        we  <= w;
        dat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        // Wait for ack; the run watchdog bounds a hang
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb(a, 1'b0, 32'h0);
        check_reg(q, exp);
    endtask

    task automatic wait_nmi();
        int n0 = nmis;
        int k  = 0;
        while (nmis == n0 && k < 1000) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 1000) failures++;
    endtask

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // -----------------------------------------------------------------
    // Clock, watchdog and test sequence
    // -----------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    initial begin
        #200000;
        failures++;
        report_and_stop();
    end

    initial begin
        failures = 0;
        n_checks = 0;
        rst_i = 1'b1;
        {we, cyc, stb} = 3'h0;
        adr = 8'h00;
        dat = 32'h0;
        sel = 4'hf;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Reset values, unmapped place, disabled counter
        rd_chk(CTRL_OFFSET, 32'h0);
        rd_chk(IRQ_STATUS_OFFSET, 32'h0);
        rd_chk(IRQ_MASK_OFFSET, 32'h0);
        wb(8'ha0, 1'b1, 32'hff);
        rd_chk(8'ha0, 32'h0);
        repeat (64) @(posedge clk_i);
        check_cnt(resets + nmis, 0);
        $display("test reset done");
        // Time-out resets the CPU once, flag set, enable sticks
        wb(CTRL_OFFSET, 1'b1, 32'h80);
        repeat (PER[0] + 10) @(posedge clk_i);
        check_cnt(resets, 1);
        check_cnt(rst_len, 8);
        check_cnt(nmis, 0);
        rd_chk(CTRL_OFFSET, 32'ha0);
        wb(CTRL_OFFSET, 1'b1, 32'h43);
        rd_chk(CTRL_OFFSET, 32'he3);
        $display("test cpu reset done");
        // Interrupt action, status, mask, byte select and interrupt line
        r = resets;
        wait_nmi();
        check_cnt(resets, r);
        check_reg({31'h0, nmi_long}, 32'h0);
        rd_chk(IRQ_STATUS_OFFSET, 32'h1);
        rd_chk(IRQ_STATUS_OFFSET, 32'h0);
        wb(IRQ_MASK_OFFSET, 1'b1, 32'h1);
        sel <= 4'he;
        wb(IRQ_MASK_OFFSET, 1'b1, 32'h3);
        sel <= 4'hf;
        rd_chk(IRQ_MASK_OFFSET, 32'h1);
        wait_nmi();
        repeat (2) @(posedge clk_i);
        check_reg({31'h0, irq_o}, 32'h1);
        rd_chk(IRQ_STATUS_OFFSET, 32'h1);
        check_reg({31'h0, irq_o}, 32'h0);
        $display("test interrupt done");
        // Restart keys hold off the time-out
        s = nmis;
        for (int i = 0; i < 6; i++) begin
            wb(RESTART_OFFSET, 1'b1, {24'h0, KEY_ARM});
            repeat (20) @(posedge clk_i);
            wb(RESTART_OFFSET, 1'b1, {24'h0, KEY_FIRE});
            repeat (40) @(posedge clk_i);
        end
        check_cnt(nmis, s);
        rd_chk(IRQ_STATUS_OFFSET, 32'h2);
        rd_chk(RESTART_OFFSET, 32'h0);
        $display("test restart done");
        // Every period code gives its cycle count; restart first so count starts low
        for (int p = 0; p < 4; p++) begin
            wb(RESTART_OFFSET, 1'b1, {24'h0, KEY_ARM});
            wb(RESTART_OFFSET, 1'b1, {24'h0, KEY_FIRE});
            wb(CTRL_OFFSET, 1'b1, 32'hc0 | p);
            wait_nmi();
            s = stamp;
            wait_nmi();
            check_cnt(stamp - s, PER[p]);
        end
        $display("test periods done");
        // Chip reset in mid-run clears enable and source flag
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd_chk(CTRL_OFFSET, 32'h0);
        rd_chk(IRQ_STATUS_OFFSET, 32'h0);
        repeat (2 * PER[0]) @(posedge clk_i);
        check_cnt(resets + nmis, 0);
        $display("test chip reset done");
        report_and_stop();
    end
endmodule // testbench

// ### core/watchdog_counter.sv
// Free counter that counts enabled cycles up to a terminal value.
// Assumes terminal value is stable while counting; reload has priority.
module watchdog_counter #(
    parameter int unsigned WIDTH = 27
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             run_i,
    input  wire logic             reload_i,
    input  wire logic [WIDTH-1:0] last_i,
    output logic      [WIDTH-1:0] count_o,
    output logic                  expire_o
);

    // ------------------------------------------------------------------
    // Count and terminal detect
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    wire              at_last = run_i && (count_q >= last_i);

    // Wrap at the terminal value so the period repeats
    assign count_d  = (reload_i || at_last) ? '0 : count_q + WIDTH'(1);
    assign count_o  = count_q;
    assign expire_o = at_last && !reload_i;

    // Counter register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= '0;
        end else if (run_i || reload_i) begin
            count_q <= count_d;
        end
    end

endmodule // watchdog_counter

// ### core/watchdog_pkg.sv
// Shared constants and types for the watchdog timer control block.
// Assumes a single 40 MHz system clock and a classic Wishbone slave port.
package watchdog_pkg;

    // ------------------------------------------------------------------
    // Bus geometry and register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W            = 8;
    localparam int unsigned DATA_W            = 32;
    localparam logic [7:0]  CTRL_OFFSET       = 8'h90;
    localparam logic [7:0]  RESTART_OFFSET    = 8'h94;
    localparam logic [7:0]  IRQ_STATUS_OFFSET = 8'h98;
    localparam logic [7:0]  IRQ_MASK_OFFSET   = 8'h9c;

    // ------------------------------------------------------------------
    // Control register fields and reset value
    // ------------------------------------------------------------------
    localparam int unsigned EN_BIT     = 7;
    localparam int unsigned ACTION_BIT = 6;
    localparam int unsigned SRC_BIT    = 5;
    localparam int unsigned PERIOD_LSB = 0;
    localparam int unsigned PERIOD_W   = 2;
    localparam logic [7:0]  CTRL_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Restart keys
    // ------------------------------------------------------------------
    localparam logic [7:0] KEY_ARM  = 8'ha5;
    localparam logic [7:0] KEY_FIRE = 8'h5a;

    // ------------------------------------------------------------------
    // Time-out periods in system clock cycles
    // ------------------------------------------------------------------
    localparam int unsigned CNT_W     = 27;
    localparam int unsigned PERIOD_00 = 134217728;
    localparam int unsigned PERIOD_01 = 33554432;
    localparam int unsigned PERIOD_10 = 4194304;
    localparam int unsigned PERIOD_11 = 262144;

    // ------------------------------------------------------------------
    // CPU reset pulse and interrupt status layout
    // ------------------------------------------------------------------
    localparam logic [3:0]  RESET_PULSE_LEN = 4'h8;
    localparam int unsigned IRQ_W           = 2;
    localparam int unsigned IRQ_TIMEOUT_BIT = 0;
    localparam int unsigned IRQ_RESTART_BIT = 1;

    // Restart key sequence state
    typedef enum logic {
        KEY_IDLE,
        KEY_ARMED
    } key_state_t;

endpackage

// ### core/watchdog_timer_control.sv
// Watchdog timer control: control register, restart keys, time-out actions.
// Assumes rst_i is the full-chip reset and a classic Wishbone master.
//
// Contract
// [R1] Control bit 7 enables counting system clocks
// [R2] Action bit zero: time-out resets the CPU
// [R3] Action bit one: time-out raises NMI instead
// [R4] Source flag bit 5 reads zero after chip reset
// [R5] Every time-out sets the source flag
// [R6] Period field selects 2^27, 2^25, 2^22, 2^18
// [R7] Enable cannot be cleared except by chip reset
// [R8] Writes A5h then 5Ah at 94h restart counting
module watchdog_timer_control #(
    parameter int unsigned PERIOD_SEL_00 = watchdog_pkg::PERIOD_00,
    parameter int unsigned PERIOD_SEL_01 = watchdog_pkg::PERIOD_01,
    parameter int unsigned PERIOD_SEL_10 = watchdog_pkg::PERIOD_10,
    parameter int unsigned PERIOD_SEL_11 = watchdog_pkg::PERIOD_11
) (
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    input  wire logic [watchdog_pkg::ADDR_W-1:0]   adr_i,
    input  wire logic [watchdog_pkg::DATA_W-1:0]   dat_i,
    output logic      [watchdog_pkg::DATA_W-1:0]   dat_o,
    input  wire logic                              we_i,
    input  wire logic [3:0]                        sel_i,
    input  wire logic                              cyc_i,
    input  wire logic                              stb_i,
    output logic                                   ack_o,
    output logic                                   irq_o,
    output logic                                   cpu_reset_o,
    output logic                                   nmi_o
);
    import watchdog_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic                 ack_q;
    logic [DATA_W-1:0]    rdata_q;
    logic                 en_q;
    logic                 action_q;
    logic                 src_q;
    logic [PERIOD_W-1:0]  period_q;
    key_state_t           key_q;
    key_state_t           key_d;
    logic [IRQ_W-1:0]     status_q;
    logic [IRQ_W-1:0]     status_d;
    logic [IRQ_W-1:0]     mask_q;
    logic                 irq_q;
    logic                 nmi_q;
    logic [3:0]           rst_cnt_q;
    logic                 cpu_reset_q;
    logic [CNT_W-1:0]     count;
    logic                 expire;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // New access seen in the cycle before ack rises
    wire access     = cyc_i && stb_i && !ack_q;
    wire wr_lane0   = access && we_i && sel_i[0];
    wire rd_access  = access && !we_i;
    wire hit_ctrl   = (adr_i == CTRL_OFFSET);
    wire hit_rst    = (adr_i == RESTART_OFFSET);
    wire hit_status = (adr_i == IRQ_STATUS_OFFSET);
    wire hit_mask   = (adr_i == IRQ_MASK_OFFSET);
    wire wr_ctrl    = wr_lane0 && hit_ctrl;
    wire wr_key     = wr_lane0 && hit_rst;
    wire wr_mask    = wr_lane0 && hit_mask;
    wire rd_status  = rd_access && hit_status;
    wire [7:0] wbyte = dat_i[7:0];

    // Read view of the control register, bits 4:2 read zero
    wire [7:0] ctrl_view = {en_q, action_q, src_q, 3'h0, period_q};

    // Read multiplexer; restart register and unmapped read zero
    wire [DATA_W-1:0] rmux =
        hit_ctrl   ? {24'h000000, ctrl_view} :
        hit_status ? {{(DATA_W-IRQ_W){1'b0}}, status_q} :
        hit_mask   ? {{(DATA_W-IRQ_W){1'b0}}, mask_q} :
                     {DATA_W{1'b0}};

    // Acknowledge one cycle after the strobe, then drop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q   <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q   <= access;
            rdata_q <= rd_access ? rmux : '0;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // Enable can be set by software but only cleared by chip reset
    wire en_d = en_q || (wr_ctrl && wbyte[EN_BIT]);                      // [R7]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_q     <= CTRL_RESET[EN_BIT];                                // [R7]
            action_q <= CTRL_RESET[ACTION_BIT];
            period_q <= CTRL_RESET[PERIOD_LSB +: PERIOD_W];
        end else begin
            en_q <= en_d;
            if (wr_ctrl) begin
                action_q <= wbyte[ACTION_BIT];
                period_q <= wbyte[PERIOD_LSB +: PERIOD_W];
            end
        end
    end

    // Reset source flag: zero after chip reset, set on any time-out
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_q <= CTRL_RESET[SRC_BIT];                                  // [R4]
        end else if (expire) begin
            src_q <= 1'b1;                                                 // [R5]
        end
    end

    // ------------------------------------------------------------------
    // Restart key sequence
    // ------------------------------------------------------------------
    // Any gap between the two keys without a time-out is allowed; a wrong value or a time-out disarms
    always_comb begin
        key_d = key_q;
        if (expire) begin
            key_d = KEY_IDLE;
        end else if (wr_key) begin
            unique case (key_q)
                KEY_IDLE:  key_d = (wbyte == KEY_ARM) ? KEY_ARMED : KEY_IDLE;
                KEY_ARMED: key_d = (wbyte == KEY_ARM) ? KEY_ARMED : KEY_IDLE;
            endcase
        end
    end

    // Second key while armed reloads the count
    wire restart = wr_key && (key_q == KEY_ARMED) && (wbyte == KEY_FIRE); // [R8]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_q <= KEY_IDLE;
        end else begin
            key_q <= key_d;                                                // [R8]
        end
    end

    // ------------------------------------------------------------------
    // Time-out counter
    // ------------------------------------------------------------------
    // Terminal count for the selected period
    wire [CNT_W-1:0] last_00 = CNT_W'(PERIOD_SEL_00 - 1);
    wire [CNT_W-1:0] last_01 = CNT_W'(PERIOD_SEL_01 - 1);
    wire [CNT_W-1:0] last_10 = CNT_W'(PERIOD_SEL_10 - 1);
    wire [CNT_W-1:0] last_11 = CNT_W'(PERIOD_SEL_11 - 1);
    wire [CNT_W-1:0] last_sel =
        (period_q == 2'h0) ? last_00 :                                     // [R6]
        (period_q == 2'h1) ? last_01 :
        (period_q == 2'h2) ? last_10 : last_11;

    // Counting runs only while enabled
    watchdog_counter #(
        .WIDTH    (CNT_W)
    ) u_counter (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .run_i    (en_q),                                                  // [R1]
        .reload_i (restart),                                               // [R8]
        .last_i   (last_sel),
        .count_o  (count),
        .expire_o (expire)
    );

    // ------------------------------------------------------------------
    // Time-out actions
    // ------------------------------------------------------------------
    // Reset pulse held for a fixed number of cycles, or one NMI pulse
    wire to_reset = expire && !action_q;                                   // [R2]
    wire to_nmi   = expire && action_q;                                    // [R3]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_cnt_q   <= 4'h0;
            cpu_reset_q <= 1'b0;
            nmi_q       <= 1'b0;
        end else begin
            nmi_q <= to_nmi;                                               // [R3]
            if (to_reset) begin
                rst_cnt_q   <= RESET_PULSE_LEN - 4'h1;                     // [R2]
                cpu_reset_q <= 1'b1;
            end else if (rst_cnt_q != 4'h0) begin
                rst_cnt_q   <= rst_cnt_q - 4'h1;
            end else begin
                cpu_reset_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    // Read clears status; a new event in the same cycle wins
    wire [IRQ_W-1:0] events = {restart, expire};
    assign status_d = (rd_status ? {IRQ_W{1'b0}} : status_q) | events;

    // Mask write counts at once so the interrupt line never lags it
    wire [IRQ_W-1:0] mask_d = wr_mask ? wbyte[IRQ_W-1:0] : mask_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_q <= '0;
            mask_q   <= '0;
            irq_q    <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q   <= mask_d;
            irq_q    <= |(status_d & mask_d);
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign ack_o       = ack_q;
    assign dat_o       = rdata_q;
    assign irq_o       = irq_q;
    assign cpu_reset_o = cpu_reset_q;
    assign nmi_o       = nmi_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Key write sequences
    sequence s_arm_write;
        wr_key && (wbyte == KEY_ARM);
    endsequence

    sequence s_fire_write;
        wr_key && (wbyte == KEY_FIRE);
    endsequence

    sequence s_armed_fire;
        (key_q == KEY_ARMED) ##0 s_fire_write;
    endsequence

    a_ack_single_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held for more than one cycle");

    a_counter_stopped: assert property (!en_q |=> $stable(count) && !expire) // [R1]
        else $error("counter moved while disabled");

    a_reset_action: assert property (                                      // [R2]
        (expire && !action_q) |=> cpu_reset_o [*8] ##1 !cpu_reset_o)
        else $error("time-out with reset action gave wrong reset pulse");

    a_nmi_action: assert property (                                        // [R3]
        (expire && action_q) |=> nmi_o && !$rose(cpu_reset_o) ##1 !nmi_o)
        else $error("time-out with nmi action gave wrong outputs");

    a_source_cleared: assert property (                                    // [R4]
        disable iff (1'b0) rst_i |=> !src_q)
        else $error("source flag not zero after chip reset");

    a_source_set: assert property (                                        // [R5]
        expire |=> src_q ##1 (src_q && $stable(src_q)) [*2])
        else $error("source flag not set by time-out");

    a_period_length: assert property (expire |-> count == last_sel)        // [R6]
        else $error("time-out at wrong count");

    a_enable_locked: assert property (en_q |=> en_q)                       // [R7]
        else $error("enable cleared without chip reset");

    a_restart_keys: assert property (                                      // [R8]
        s_armed_fire |=> (count == '0) && status_q[IRQ_RESTART_BIT])
        else $error("key sequence did not reload the counter");

    a_key_arming: assert property (s_arm_write ##0 !expire |=> key_q == KEY_ARMED) // [R8]
        else $error("first key did not arm the restart");

    a_key_disarm: assert property (expire |=> key_q == KEY_IDLE)           // [R8]
        else $error("time-out left the restart armed");

    a_enable_set: assert property (wr_ctrl && wbyte[EN_BIT] |=> en_q)      // [R1]
        else $error("enable write did not start the watchdog");

    a_reset_cause: assert property (                                       // [R2]
        $rose(cpu_reset_o) |-> $past(expire) && !$past(action_q))
        else $error("cpu reset without a reset-action time-out");

    a_nmi_cause: assert property (nmi_o |-> $past(expire) && $past(action_q)) // [R3]
        else $error("nmi without an nmi-action time-out");

    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("access not acknowledged after one cycle");

    a_read_idle: assert property (!ack_o |-> dat_o == '0)
        else $error("read data not zero outside acknowledge");

    a_irq_level: assert property (irq_o == (|(status_q & mask_q)))
        else $error("interrupt line differs from unmasked status");

    a_irq_follows: assert property (
        (|(status_q & mask_q)) && !rd_status |-> irq_o || $past(rd_status))
        else $error("interrupt low with unmasked status set");

endmodule // watchdog_timer_control
